// ---- rbr_board.sv ----
// Purpose: board wire seen at the rotator output pins
// Assumes: no pull resistors on the pins
// Notes: a released pin shows the inverse of its last driven level
`timescale 1ns/1ps
module rbr_board (
    // clock of the driving side
    input wire logic clk,
    // pins from the rotator
    input wire logic [7:0] drv,
    input wire logic [7:0] drv_oe_n,
    // resolved level
    output logic [7:0] pin
);
    logic [7:0] last_q = 8'h00;
    // sampled at the edge so a data change and a release in one step cannot race
    always @(posedge clk) begin
        last_q <= (drv & ~drv_oe_n) | (last_q & drv_oe_n);
    end
    // a floating pin must not pass for a stale value
    assign pin = (drv & ~drv_oe_n) | (~last_q & drv_oe_n);
endmodule

// ---- rbr_pkg.sv ----
// Purpose: shared constants and types for the registered byte rotator
// Assumes: one clock, synchronous active-low reset
// Notes: widths and preset value live here
package rbr_pkg;
    localparam int RBR_DATA_W = 8;
    localparam int RBR_SEL_W = 3;
    localparam logic [7:0] RBR_PRESET = 8'hFF;
    localparam logic [7:0] RBR_RESET_VAL = 8'hFF;
    localparam logic [2:0] RBR_SEL_NONE = 3'h0;
    localparam logic [2:0] RBR_SEL_FIVE = 3'h5;

    typedef struct packed {
        logic [7:0] word;
        logic [2:0] amount;
    } rbr_req_t;
endpackage

// ---- rbr_rotator.sv ----
// Purpose: registered 8-bit right rotator with preset and output disable
// Assumes: inputs synchronous to clk; pad logic resolves the tri-state
// Notes: output_disable only gates the drivers, never the register
`timescale 1ns/1ps

module rbr_rotator
    import rbr_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data path
    input wire logic [7:0] data_in,
    input wire logic [2:0] shift_amount_lines,
    input wire logic shift_enable,
    input wire logic output_disable,
    // output pins
    output logic [7:0] rotated_out,
    output logic [7:0] rotated_out_oe_n
);
    rbr_req_t req;
    logic [7:0] rot_q;
    logic [7:0] rot_d;
    logic [7:0] oe_n_q;

    assign req.word = data_in;
    assign req.amount = shift_amount_lines; // bit 2 is the msb

    // one generate loop, out bit i takes in bit (i+amount) mod 8
    for (genvar i = 0; i < RBR_DATA_W; i++) begin : g_bit
        logic [2:0] src;
        assign src = 3'(i) + req.amount; // wrap in 3 bits
        // true polarity; enable low loads the preset
        assign rot_d[i] = shift_enable ? req.word[src] : RBR_PRESET[i];
    end

    // register ignores output_disable entirely
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rot_q <= RBR_RESET_VAL;
        end else begin
            rot_q <= rot_d;
        end
    end

    // enable held in a flop per style; the pad treats it as the driver gate.
    // a registered enable costs one cycle; the pad sees only this flopped enable,
    // never the raw input, so the change waits for the sampling edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            oe_n_q <= 8'hFF;
        end else begin
            oe_n_q <= {8{output_disable}};
        end
    end

    assign rotated_out = rot_q; // always the held value
    assign rotated_out_oe_n = oe_n_q;

    property p_rotate;
        @(posedge clk) disable iff (!rst_n)
        shift_enable |=> rot_q == (($past(data_in) >> $past(shift_amount_lines))
            | ($past(data_in) << (4'h8 - {1'h0, $past(shift_amount_lines)})));
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate mismatch");

    property p_wrap;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h1) |=> rot_q[7] == $past(data_in[0]);
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap bit lost");

    property p_preset;
        @(posedge clk) disable iff (!rst_n)
        !shift_enable |=> rot_q == RBR_PRESET;
    endproperty
    a_preset: assert property (p_preset) else $error("preset missing");

    property p_disable;
        @(posedge clk) disable iff (!rst_n)
        output_disable |=> rotated_out_oe_n == 8'hFF;
    endproperty
    a_disable: assert property (p_disable) else $error("outputs not disabled");

    property p_keep_shift;
        @(posedge clk) disable iff (!rst_n)
        (output_disable && shift_enable) |=>
            rot_q == (($past(data_in) >> $past(shift_amount_lines))
            | ($past(data_in) << (4'h8 - {1'h0, $past(shift_amount_lines)})));
    endproperty
    a_keep_shift: assert property (p_keep_shift) else $error("update stalled");

    property p_reenable;
        @(posedge clk) disable iff (!rst_n)
        !output_disable |=> rotated_out_oe_n == 8'h00 && rotated_out == ($past(shift_enable)
            ? (($past(data_in) >> $past(shift_amount_lines))
            | ($past(data_in) << (4'h8 - {1'h0, $past(shift_amount_lines)})))
            : RBR_PRESET);
    endproperty
    a_reenable: assert property (p_reenable) else $error("held value not shown");

    property p_zero;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == RBR_SEL_NONE) |=> rot_q == $past(data_in);
    endproperty
    a_zero: assert property (p_zero) else $error("zero shift altered data");

    property p_five;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == RBR_SEL_FIVE) |=>
            rot_q[7] == $past(data_in[4]) && rot_q[6] == $past(data_in[3]);
    endproperty
    a_five: assert property (p_five) else $error("shift five wrong");

    property p_msb;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h4) |=> rot_q[0] == $past(data_in[4]);
    endproperty
    a_msb: assert property (p_msb) else $error("select order wrong");

    // reset loads the preset pattern and releases the pins
    property p_reset;
        @(posedge clk)
        !rst_n |=> rot_q == RBR_RESET_VAL && rotated_out_oe_n == 8'hFF;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");

    // one check per amount, spelled out apart from the index arithmetic
    property p_amt0;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h0) |=> rot_q == $past(data_in);
    endproperty
    a_amt0: assert property (p_amt0) else $error("amount 0 wrong");

    property p_amt1;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h1) |=> rot_q == {$past(data_in[0]), $past(data_in[7:1])};
    endproperty
    a_amt1: assert property (p_amt1) else $error("amount 1 wrong");

    property p_amt2;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h2) |=> rot_q == {$past(data_in[1:0]), $past(data_in[7:2])};
    endproperty
    a_amt2: assert property (p_amt2) else $error("amount 2 wrong");

    property p_amt3;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h3) |=> rot_q == {$past(data_in[2:0]), $past(data_in[7:3])};
    endproperty
    a_amt3: assert property (p_amt3) else $error("amount 3 wrong");

    property p_amt4;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h4) |=> rot_q == {$past(data_in[3:0]), $past(data_in[7:4])};
    endproperty
    a_amt4: assert property (p_amt4) else $error("amount 4 wrong");

    property p_amt5;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h5) |=> rot_q == {$past(data_in[4:0]), $past(data_in[7:5])};
    endproperty
    a_amt5: assert property (p_amt5) else $error("amount 5 wrong");

    property p_amt6;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h6) |=> rot_q == {$past(data_in[5:0]), $past(data_in[7:6])};
    endproperty
    a_amt6: assert property (p_amt6) else $error("amount 6 wrong");

    property p_amt7;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h7) |=> rot_q == {$past(data_in[6:0]), $past(data_in[7])};
    endproperty
    a_amt7: assert property (p_amt7) else $error("amount 7 wrong");

    // per-bit view, so a stuck or crossed bit names itself
    for (genvar j = 0; j < RBR_DATA_W; j++) begin : g_chk
        property p_bit;
            @(posedge clk) disable iff (!rst_n)
            shift_enable |=> rot_q[j] == $past(data_in[3'(j) + shift_amount_lines]);
        endproperty
        a_bit: assert property (p_bit) else $error("bit source wrong");

        property p_bit_preset;
            @(posedge clk) disable iff (!rst_n)
            !shift_enable |=> rot_q[j] == 1'h1;
        endproperty
        a_bit_preset: assert property (p_bit_preset) else $error("bit not preset");

        property p_bit_off;
            @(posedge clk) disable iff (!rst_n)
            output_disable |=> rotated_out_oe_n[j] == 1'h1;
        endproperty
        a_bit_off: assert property (p_bit_off) else $error("bit still driven");
    end

    // preset still lands while the pins are off
    property p_preset_hidden;
        @(posedge clk) disable iff (!rst_n)
        (output_disable && !shift_enable) |=> rot_q == RBR_PRESET;
    endproperty
    a_preset_hidden: assert property (p_preset_hidden) else $error("preset lost");

    // toggling the disable must not disturb what the register loads
    property p_od_transparent;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && $changed(output_disable)) |=>
            rot_q == (($past(data_in) >> $past(shift_amount_lines))
            | ($past(data_in) << (4'h8 - {1'h0, $past(shift_amount_lines)})));
    endproperty
    a_od_transparent: assert property (p_od_transparent) else $error("load moved");

    // a one in stays a one out, a zero stays a zero
    property p_all_ones;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && data_in == 8'hFF) |=> rot_q == 8'hFF;
    endproperty
    a_all_ones: assert property (p_all_ones) else $error("ones inverted");

    property p_all_zeros;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && data_in == 8'h00) |=> rot_q == 8'h00;
    endproperty
    a_all_zeros: assert property (p_all_zeros) else $error("zeros inverted");

    // all eight drivers switch together
    property p_oe_uniform;
        @(posedge clk) disable iff (!rst_n)
        rotated_out_oe_n == {8{rotated_out_oe_n[0]}};
    endproperty
    a_oe_uniform: assert property (p_oe_uniform) else $error("drivers split");

    // each select line carries its own binary weight
    property p_sel_w0;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h1) |=> rot_q[0] == $past(data_in[1]);
    endproperty
    a_sel_w0: assert property (p_sel_w0) else $error("select 0 weight wrong");

    property p_sel_w1;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h2) |=> rot_q[7] == $past(data_in[1]);
    endproperty
    a_sel_w1: assert property (p_sel_w1) else $error("select 1 weight wrong");

    property p_sel_w2;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines == 3'h4) |=> rot_q[7] == $past(data_in[3]);
    endproperty
    a_sel_w2: assert property (p_sel_w2) else $error("select 2 weight wrong");

    // for any nonzero amount the high end is refilled from the low end
    property p_wrap_any;
        @(posedge clk) disable iff (!rst_n)
        (shift_enable && shift_amount_lines != 3'h0) |=> rot_q[7] == $past(data_in[shift_amount_lines - 3'h1]);
    endproperty
    a_wrap_any: assert property (p_wrap_any) else $error("wrap missing");

    // the low end takes the bit that many places up
    property p_low_fill;
        @(posedge clk) disable iff (!rst_n)
        shift_enable |=> rot_q[0] == $past(data_in[shift_amount_lines]);
    endproperty
    a_low_fill: assert property (p_low_fill) else $error("low bit wrong");

    // with pins on, a preset is what the board sees
    property p_preset_shown;
        @(posedge clk) disable iff (!rst_n)
        (!shift_enable && !output_disable) |=> rotated_out == 8'hFF && rotated_out_oe_n == 8'h00;
    endproperty
    a_preset_shown: assert property (p_preset_shown) else $error("preset not shown");

    // pins return one edge after the disable drops
    property p_back_on;
        @(posedge clk) disable iff (!rst_n)
        $fell(output_disable) |=> rotated_out_oe_n == 8'h00;
    endproperty
    a_back_on: assert property (p_back_on) else $error("pins stay off");
endmodule

// ---- test_registered_byte_rotator.sv ----
// Purpose: self-checking bench for the byte rotator
// Assumes: inputs change by nonblocking assignment at rising edges
// Notes: result is read 1 ns after the sampling edge
`timescale 1ns/1ps
module test_registered_byte_rotator;
    import rbr_pkg::*;
    logic clk = 0, rst_n = 0, en = 1, od = 0;
    logic [7:0] d = 8'h00, q, q_oe_n, pin;
    logic [2:0] a = 3'h0;
    int failures = 0, checks_done = 0;
    rbr_rotator rbr_rotator_i (.clk(clk), .rst_n(rst_n), .data_in(d),
        .shift_amount_lines(a), .shift_enable(en), .output_disable(od),
        .rotated_out(q), .rotated_out_oe_n(q_oe_n));
    rbr_board rbr_board_i (.clk(clk), .drv(q), .drv_oe_n(q_oe_n), .pin(pin));
    initial forever #4 clk = ~clk;
    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(logic [7:0] dv, logic [2:0] av, logic ev, logic ov);
        @(posedge clk);
        d <= dv;
        a <= av;
        en <= ev;
        od <= ov;
        @(posedge clk);
        #1;
    endtask
    task automatic test_rotate();
        for (int i = 0; i < 8; i++) begin
            step(8'h80, i[2:0], 1'b1, 1'b0);
            chk("rotated_out", 8'h80 >> i, q);
        end
        step(8'h01, 3'h1, 1'b1, 1'b0);
        chk("wrap", 8'h80, q);
        step(8'h18, RBR_SEL_FIVE, 1'b1, 1'b0);
        chk("amount five", 8'hC0, q);
        step(8'hFF, 3'h6, 1'b1, 1'b0);
        chk("all ones", 8'hFF, q);
        $display("test rotate done");
    endtask
    task automatic test_preset();
        step(8'h00, 3'h0, 1'b0, 1'b0);
        chk("preset", 8'hFF, q);
        step(8'h01, 3'h0, 1'b1, 1'b0);
        chk("reload", 8'h01, pin);
        $display("test preset done");
    endtask
    task automatic test_disable();
        step(8'h80, 3'h3, 1'b1, 1'b1);
        chk("oe_n off", 8'hFF, q_oe_n);
        chk("pin off", 8'hFE, pin);
        chk("hidden shift", 8'h10, q);
        step(8'h80, 3'h3, 1'b1, 1'b0);
        chk("oe_n on", 8'h00, q_oe_n);
        chk("pin on", 8'h10, pin);
        $display("test disable done");
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("reset value", RBR_RESET_VAL, q);
        test_rotate();
        test_preset();
        test_disable();
        test_done();
    end
endmodule
